// [design/qlm_defs.vh]
// constants for the four-line serial multiplexer: register map, fields,
// baud rates and silo sizes; assumes a 32-bit wishbone word per register.
// What this block does
// - device_clear self-clears after its clear
// - device_clear zeroes tie, sae, scan, loopback
// - six control bits writable, master clear zeroes
// - tx_control_reg writable, reset clears it and dtr
// - status bits read-only, writes ignored
// - tx_ready low until line selected and scanning
// - tx_ready when enabled line can take character
// - tx line field names the ready line
// - rx buffer read-only, line params write-only
// - modem status read-only, tx data write-only
// - rx_line_enable clear blocks line from silo
// - device_clear empties the receive silo
// - four lines numbered zero to three
// - staggered loopback pairs 0-1, 2-3
// - fifteen selectable baud rates
// - loopback_select loops each transmitter internally
// - silo_alarm sets on sixteenth character
// - sixty-four deep silo, overrun on next
// - receiver interrupt beats transmitter interrupt
`ifndef QLM_DEFS_VH
`define QLM_DEFS_VH
// ====================================================================
// register byte offsets
`define QLM_OFF_CSR 8'h00
`define QLM_OFF_RX_BUFFER_REG 8'h04
`define QLM_OFF_TCR 8'h08
`define QLM_OFF_MSR 8'h0C
// ====================================================================
// control and status bits
`define QLM_CSR_STAG 2
`define QLM_CSR_LOOP 3
`define QLM_CSR_DCLR 4
`define QLM_CSR_SCAN 5
`define QLM_CSR_RIE 6
`define QLM_CSR_RX_DONE 7
`define QLM_CSR_TLA 8
`define QLM_CSR_TLB 9
`define QLM_CSR_SAE 12
`define QLM_CSR_SA 13
`define QLM_CSR_TIE 14
`define QLM_CSR_TX_READY 15
// receive buffer and line parameter fields
`define QLM_RB_VALID 15
`define QLM_RB_OVRN 14
`define QLM_RB_LINE 8
`define QLM_LP_RATE 8
`define QLM_LP_RXEN 12
// transmit control and modem status fields
`define QLM_TC_DTR 8
`define QLM_MS_RING 8
// ====================================================================
// sizes and counts
`define QLM_LINES 4
`define QLM_SILO_DEPTH 7'h40
`define QLM_SILO_ALARM_AT 7'h0F
`define QLM_FRAME_BITS 4'h9
`define QLM_ZERO16 16'h0000
// baud rates in bits per second
`define QLM_BAUD_50 50
`define QLM_BAUD_75 75
`define QLM_BAUD_110 110
`define QLM_BAUD_135 135
`define QLM_BAUD_150 150
`define QLM_BAUD_300 300
`define QLM_BAUD_600 600
`define QLM_BAUD_1200 1200
`define QLM_BAUD_1800 1800
`define QLM_BAUD_2000 2000
`define QLM_BAUD_2400 2400
`define QLM_BAUD_3600 3600
`define QLM_BAUD_4800 4800
`define QLM_BAUD_7200 7200
`define QLM_BAUD_9600 9600
`endif

// [design/qlm_line.v]
// one serial line: 8N1 transmitter and receiver at a given bit period.
// assumes the bit period in clocks is at least four and stable in a frame.
`timescale 1ns/10ps
`include "qlm_defs.vh"
module qlm_line (
    input wire clk,
    input wire rst_n,
    input wire clr,
    input wire [21:0] div,
    input wire load,
    input wire [7:0] load_data,
    output wire idle,
    output wire txd,
    input wire rxd,
    output reg rx_stb,
    output reg [7:0] rx_data
);
    // ================================================================
    // transmitter
    reg [21:0] tcnt_reg; // clocks left in current bit
    reg [3:0] tbits_reg; // bits left after current one
    reg tbusy_reg; // frame in progress
    reg [9:0] tsh_reg; // stop, data, start; bit 0 on the wire
    assign idle = ~tbusy_reg;
    assign txd = tsh_reg[0];
    // shift a frame out, lsb first, mark when idle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tcnt_reg <= 22'h00_0000;
            tbits_reg <= 4'h0;
            tbusy_reg <= 1'b0;
            tsh_reg <= 10'h3FF;
        end else if (clr) begin
            // a clear stops transmission at once
            tbusy_reg <= 1'b0;
            tsh_reg <= 10'h3FF;
        end else if (load && !tbusy_reg) begin
            tsh_reg <= {1'b1, load_data, 1'b0};
            tbits_reg <= `QLM_FRAME_BITS;
            tcnt_reg <= div;
            tbusy_reg <= 1'b1;
        end else if (tbusy_reg) begin
            if (tcnt_reg == 22'h00_0001) begin
                tsh_reg <= {1'b1, tsh_reg[9:1]};
                tcnt_reg <= div;
                tbits_reg <= tbits_reg - 4'h1;
                if (tbits_reg == 4'h0) begin
                    tbusy_reg <= 1'b0;
                end
            end else begin
                tcnt_reg <= tcnt_reg - 22'h00_0001;
            end
        end
    end
    // ================================================================
    // receiver
    reg [21:0] rcnt_reg; // clocks to next sample point
    reg [3:0] rbits_reg; // samples left after current one
    reg rbusy_reg; // frame in progress
    reg [7:0] rsh_reg; // data being assembled
    // find start edge, sample mid-bit, pulse on a good stop bit
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rcnt_reg <= 22'h00_0000;
            rbits_reg <= 4'h0;
            rbusy_reg <= 1'b0;
            rsh_reg <= 8'h00;
            rx_stb <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            rx_stb <= 1'b0;
            if (clr) begin
                rbusy_reg <= 1'b0;
            end else if (!rbusy_reg) begin
                if (!rxd) begin
                    rbusy_reg <= 1'b1;
                    rbits_reg <= `QLM_FRAME_BITS;
                    rcnt_reg <= {1'b0, div[21:1]};
                end
            end else if (rcnt_reg == 22'h00_0001) begin
                rcnt_reg <= div;
                rbits_reg <= rbits_reg - 4'h1;
                if (rbits_reg == `QLM_FRAME_BITS) begin
                    // start bit gone high again: a glitch
                    rbusy_reg <= ~rxd;
                end else if (rbits_reg == 4'h0) begin
                    // stop sample; framing errors are dropped
                    rbusy_reg <= 1'b0;
                    rx_stb <= rxd;
                    rx_data <= rsh_reg;
                end else begin
                    rsh_reg <= {rxd, rsh_reg[7:1]};
                end
            end else begin
                rcnt_reg <= rcnt_reg - 22'h00_0001;
            end
        end
    end
endmodule

// [design/qlm_top.v]
// four-line serial multiplexer: wishbone registers, scanner, receive silo.
// assumes classic wishbone single cycles; inputs synchronous to clk.
`timescale 1ns/10ps
`include "qlm_defs.vh"
module qlm_top #(
    parameter CLK_HZ = 200000000
) (
    input wire clk,
    input wire resetn,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    input wire [3:0] ser_in,
    output wire [3:0] ser_out,
    output wire [3:0] dtr,
    input wire [3:0] carrier,
    input wire [3:0] ring,
    output reg rx_irq,
    output reg tx_irq
);
    // ================================================================
    // bit period in clocks for a rate index
    function [21:0] baud_div;
        input [3:0] idx;
        integer r;
        integer q;
        begin
            case (idx)
                4'h0: r = `QLM_BAUD_50;
                4'h1: r = `QLM_BAUD_75;
                4'h2: r = `QLM_BAUD_110;
                4'h3: r = `QLM_BAUD_135;
                4'h4: r = `QLM_BAUD_150;
                4'h5: r = `QLM_BAUD_300;
                4'h6: r = `QLM_BAUD_600;
                4'h7: r = `QLM_BAUD_1200;
                4'h8: r = `QLM_BAUD_1800;
                4'h9: r = `QLM_BAUD_2000;
                4'hA: r = `QLM_BAUD_2400;
                4'hB: r = `QLM_BAUD_3600;
                4'hC: r = `QLM_BAUD_4800;
                4'hD: r = `QLM_BAUD_7200;
                default: r = `QLM_BAUD_9600;
            endcase
            q = CLK_HZ / r;
            baud_div = q[21:0];
        end
    endfunction
    // ================================================================
    // reset release through two flops
    reg rs1_reg;
    reg rst_n; // synchronised reset used everywhere
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rs1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_reg <= 1'b1;
            rst_n <= rs1_reg;
        end
    end
    // ================================================================
    // control state
    reg loop_reg; // loopback_select
    reg stag_reg; // staggered pairing in loopback
    reg scan_reg; // scan_enable
    reg rie_reg; // rx_irq_enable
    reg sae_reg; // silo_alarm_enable
    reg tie_reg; // tx_irq_enable
    reg dclr_reg; // device_clear, high for one cycle
    reg [3:0] tcr_reg; // transmit line enables
    reg [3:0] dtr_reg; // per-line terminal ready
    reg [3:0] rxen_reg; // rx_line_enable per line
    reg [15:0] rate_reg; // four bits of rate index per line
    reg [1:0] ptr_reg; // scanner line number
    wire [3:0] idle; // transmitter free per line
    wire [3:0] txd; // transmitter outputs
    wire [3:0] rx_stb; // received character pulses
    wire [31:0] rx_data; // received characters, 8 bits per line
    wire req = cyc_i & stb_i;
    wire wr_ev = req & ack_o & we_i; // write takes effect here
    wire rd_ev = req & ack_o & ~we_i; // read side effects here
    wire [15:0] wm = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [15:0] wd = dat_i[15:0] & wm;
    wire tx_ready = scan_reg & tcr_reg[ptr_reg] & idle[ptr_reg];
    wire tdr_wr = wr_ev & (adr_i == `QLM_OFF_MSR) & sel_i[0];
    reg [15:0] csr_now; // control bits as stored
    reg [15:0] csr_new; // control bits after a write
    // merge a csr write into the writable bits only
    always @* begin
        csr_now = `QLM_ZERO16;
        csr_now[`QLM_CSR_STAG] = stag_reg;
        csr_now[`QLM_CSR_LOOP] = loop_reg;
        csr_now[`QLM_CSR_SCAN] = scan_reg;
        csr_now[`QLM_CSR_RIE] = rie_reg;
        csr_now[`QLM_CSR_SAE] = sae_reg;
        csr_now[`QLM_CSR_TIE] = tie_reg;
        csr_new = (csr_now & ~wm) | wd;
    end
    // register writes and device clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // master clear
            loop_reg <= 1'b0;
            stag_reg <= 1'b0;
            scan_reg <= 1'b0;
            rie_reg <= 1'b0;
            sae_reg <= 1'b0;
            tie_reg <= 1'b0;
            dclr_reg <= 1'b0;
            tcr_reg <= 4'h0;
            dtr_reg <= 4'h0;
            rxen_reg <= 4'h0;
            rate_reg <= `QLM_ZERO16;
        end else begin
            dclr_reg <= 1'b0;
            if (wr_ev && adr_i == `QLM_OFF_CSR) begin
                // status positions are not stored anywhere
                stag_reg <= csr_new[`QLM_CSR_STAG];
                loop_reg <= csr_new[`QLM_CSR_LOOP];
                scan_reg <= csr_new[`QLM_CSR_SCAN];
                rie_reg <= csr_new[`QLM_CSR_RIE];
                sae_reg <= csr_new[`QLM_CSR_SAE];
                tie_reg <= csr_new[`QLM_CSR_TIE];
                dclr_reg <= wd[`QLM_CSR_DCLR];
            end
            if (wr_ev && adr_i == `QLM_OFF_RX_BUFFER_REG && sel_i[1]) begin
                // line parameter write; line number in low byte
                rate_reg[{wd[1:0], 2'b00} +: 4] <= wd[`QLM_LP_RATE +: 4];
                rxen_reg[wd[1:0]] <= wd[`QLM_LP_RXEN];
            end
            if (wr_ev && adr_i == `QLM_OFF_TCR) begin
                tcr_reg <= (tcr_reg & ~wm[3:0]) | wd[3:0];
                dtr_reg <= (dtr_reg & ~wm[11:8]) | wd[`QLM_TC_DTR +: 4];
            end
            if (dclr_reg) begin
                tie_reg <= 1'b0;
                sae_reg <= 1'b0;
                scan_reg <= 1'b0;
                loop_reg <= 1'b0;
            end
        end
    end
    assign dtr = dtr_reg;
    // ================================================================
    // transmit scanner: rests on a ready line, else moves on
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_reg <= 2'b00;
        end else if (!scan_reg || dclr_reg) begin
            ptr_reg <= 2'b00;
        end else if (!tx_ready || tdr_wr) begin
            ptr_reg <= ptr_reg + 2'b01;
        end
    end
    // ================================================================
    // lines, with internal and staggered loopback
    genvar i;
    generate
        for (i = 0; i < `QLM_LINES; i = i + 1) begin : g_line
            // staggered partner of line i is line i xor 1
            wire rx_src = !loop_reg ? ser_in[i] :
                stag_reg ? txd[i ^ 1] : txd[i];
            qlm_line u_line (
                .clk(clk),
                .rst_n(rst_n),
                .clr(dclr_reg),
                .div(baud_div(rate_reg[4 * i +: 4])),
                .load(tdr_wr && tx_ready && ptr_reg == i),
                .load_data(wd[7:0]),
                .idle(idle[i]),
                .txd(txd[i]),
                .rxd(rx_src),
                .rx_stb(rx_stb[i]),
                .rx_data(rx_data[8 * i +: 8])
            );
            // line output idles at mark while looped inside
            assign ser_out[i] = loop_reg ? 1'b1 : txd[i];
        end
    endgenerate
    // ================================================================
    // receive silo
    reg [9:0] silo_mem [0:63]; // line number and character
    reg [5:0] wp_reg; // write pointer
    reg [5:0] rp_reg; // read pointer
    reg [6:0] cnt_reg; // characters held
    reg [3:0] pend_reg; // characters waiting to enter
    reg ovr_reg; // overrun_error
    reg sa_reg; // silo_alarm
    reg [1:0] take_idx; // lowest waiting line
    reg take; // a waiting character is taken this cycle; it enters unless the silo is full
    integer k;
    wire full = (cnt_reg == `QLM_SILO_DEPTH);
    wire pop = rd_ev && adr_i == `QLM_OFF_RX_BUFFER_REG && cnt_reg != 7'h00;
    wire rb_rd = rd_ev && adr_i == `QLM_OFF_RX_BUFFER_REG;
    // pick one waiting line per cycle, lowest number first
    always @* begin
        take = 1'b0;
        take_idx = 2'b00;
        for (k = `QLM_LINES - 1; k >= 0; k = k - 1) begin
            if (pend_reg[k]) begin
                take = 1'b1;
                take_idx = k[1:0];
            end
        end
    end
    // pointer, count and flag upkeep
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg <= 6'h00;
            rp_reg <= 6'h00;
            cnt_reg <= 7'h00;
            pend_reg <= 4'h0;
            ovr_reg <= 1'b0;
            sa_reg <= 1'b0;
        end else if (dclr_reg) begin
            // discard everything held
            wp_reg <= 6'h00;
            rp_reg <= 6'h00;
            cnt_reg <= 7'h00;
            pend_reg <= 4'h0;
            ovr_reg <= 1'b0;
            sa_reg <= 1'b0;
        end else begin
            // a disabled line never queues a character
            pend_reg <= (pend_reg & ~(take ? 4'h1 << take_idx : 4'h0))
                | (rx_stb & rxen_reg);
            if (take && !full) begin
                silo_mem[wp_reg] <= {take_idx,
                    rx_data[8 * take_idx +: 8]};
                wp_reg <= wp_reg + 6'h01;
            end
            if (pop) begin
                rp_reg <= rp_reg + 6'h01;
            end
            cnt_reg <= cnt_reg + ((take && !full) ? 7'h01 : 7'h00)
                - (pop ? 7'h01 : 7'h00);
            // new events win over the clear by a read
            if (take && full) begin
                ovr_reg <= 1'b1;
            end else if (rb_rd) begin
                ovr_reg <= 1'b0;
            end
            if (take && !full && cnt_reg == `QLM_SILO_ALARM_AT) begin
                sa_reg <= 1'b1;
            end else if (rb_rd) begin
                sa_reg <= 1'b0;
            end
        end
    end
    // ================================================================
    // read data, captured as the request is accepted
    reg [15:0] rd_mux;
    wire rx_done = (cnt_reg != 7'h00);
    always @* begin
        rd_mux = `QLM_ZERO16;
        case (adr_i)
            `QLM_OFF_CSR: begin
                rd_mux = csr_now;
                rd_mux[`QLM_CSR_RX_DONE] = rx_done;
                rd_mux[`QLM_CSR_TLA] = ptr_reg[0];
                rd_mux[`QLM_CSR_TLB] = ptr_reg[1];
                rd_mux[`QLM_CSR_SA] = sa_reg;
                rd_mux[`QLM_CSR_TX_READY] = tx_ready;
                rd_mux[`QLM_CSR_DCLR] = dclr_reg;
            end
            `QLM_OFF_RX_BUFFER_REG: begin
                rd_mux[9:0] = silo_mem[rp_reg];
                rd_mux[`QLM_RB_VALID] = rx_done;
                rd_mux[`QLM_RB_OVRN] = ovr_reg;
                if (!rx_done) begin
                    rd_mux[9:0] = 10'h000;
                end
            end
            `QLM_OFF_TCR: begin
                rd_mux[3:0] = tcr_reg;
                rd_mux[`QLM_TC_DTR +: 4] = dtr_reg;
            end
            `QLM_OFF_MSR: begin
                rd_mux[3:0] = carrier;
                rd_mux[`QLM_MS_RING +: 4] = ring;
            end
            default: rd_mux = `QLM_ZERO16;
        endcase
    end
    // one wait-free answer: ack the cycle after the request
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req & ~ack_o;
            if (req && !ack_o) begin
                dat_o <= {16'h0000, rd_mux};
            end
        end
    end
    // ================================================================
    // interrupt requests; receiver first
    wire rx_want = rie_reg & (sae_reg ? sa_reg : rx_done);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_irq <= 1'b0;
            tx_irq <= 1'b0;
        end else begin
            rx_irq <= rx_want;
            tx_irq <= tie_reg & tx_ready & ~rx_want;
        end
    end
endmodule

// [testbench/qlm_term_model.sv]
// terminal side of the four serial lines, with a loop-back test plug
// assumes lines idle at mark (high) and the plug feeds dtr back to modem
`timescale 1ns/10ps
module qlm_term_model (
    input wire [3:0] ser_out,
    input wire [3:0] dtr,
    input wire ext_loop,
    output wire [3:0] ser_in,
    output wire [3:0] carrier,
    output wire [3:0] ring
);
    // ================================================================
    // plug wiring
    // plugged: each transmit returns on its own receive; else mark idle
    assign ser_in = ext_loop ? ser_out : 4'hF;
    // the plug ties dtr onto carrier and ring of the same line
    assign carrier = dtr;
    assign ring = dtr;
endmodule

// [testbench/qlm_top_monitor.sv]
// checker for the multiplexer's bus answers, modem pins and interrupts
// assumes it is bound to qlm_top and sees nothing but its ports
`timescale 1ns/10ps
`include "qlm_defs.vh"
module qlm_top_monitor #(
    parameter CLK_HZ = 200000000
) (
    input wire clk,
    input wire resetn,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    input wire [3:0] ser_out,
    input wire [3:0] dtr,
    input wire rx_irq,
    input wire tx_irq
);
    // ================================================================
    // helper logic
    reg [3:0] qlm_en_reg; // line enables last written to tx control
    wire [3:0] dtr_wr = dat_i[11:8]; // dtr field of the bus data
    wire csr_rd = ack_o && !we_i && adr_i == `QLM_OFF_CSR; // csr answer
    // follow tx control writes at the edge where they take effect
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            qlm_en_reg <= 4'h0;
        end else if (ack_o && we_i && adr_i == `QLM_OFF_TCR) begin
            qlm_en_reg <= dat_i[3:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ================================================================
    // bus answer
    chk_ack_once: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_take: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in the next cycle");
    chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
        else $error("ack without a request");
    chk_data_hold: assert property (ack_o ##1 !cyc_i |-> $stable(dat_o))
        else $error("read data moved after the answer");
    chk_upper_zero: assert property (
        ack_o && !we_i |-> dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    chk_unmapped_zero: assert property (
        ack_o && !we_i && adr_i > 8'h0C |-> dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    // ================================================================
    // modem pins, ready reporting, interrupts
    chk_dtr_write: assert property (
        ack_o && we_i && adr_i == `QLM_OFF_TCR |=> dtr == $past(dtr_wr))
        else $error("dtr does not follow tx control write");
    chk_dtr_reset: assert property (
        $rose(resetn) |-> dtr == 4'h0 && ser_out == 4'hF)
        else $error("pins not at rest after reset");
    chk_ready_scan: assert property (
        csr_rd && !dat_o[`QLM_CSR_SCAN] |-> !dat_o[`QLM_CSR_TX_READY])
        else $error("tx ready while scanning is off");
    chk_ready_nolines: assert property (
        csr_rd && qlm_en_reg == 4'h0 |-> !dat_o[`QLM_CSR_TX_READY])
        else $error("tx ready with no line enabled");
    chk_line_enabled: assert property (
        csr_rd && dat_o[`QLM_CSR_TX_READY] |-> qlm_en_reg[dat_o[9:8]])
        else $error("ready line is not enabled");
    chk_irq_order: assert property (!(rx_irq && tx_irq))
        else $error("tx interrupt shown with rx pending");
endmodule
bind qlm_top qlm_top_monitor #(.CLK_HZ(CLK_HZ)) u_mon (.clk(clk),
    .resetn(resetn), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ser_out(ser_out), .dtr(dtr), .rx_irq(rx_irq), .tx_irq(tx_irq));

// [testbench/quad_async_line_mux_control_tb.sv]
// self-checking bench for the four-line serial multiplexer
// assumes qlm_top, the terminal model and the checker are compiled first
`timescale 1ns/10ps
`include "qlm_defs.vh"
module quad_async_line_mux_control_tb;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg cyc_i = 1'b0;
    reg stb_i = 1'b0;
    reg we_i = 1'b0;
    reg [3:0] sel_i = 4'hF; // both used lanes always on
    reg [7:0] adr_i = 8'h00;
    reg [31:0] dat_i = 32'h0000_0000;
    reg ext_loop = 1'b0; // test plug on the far side
    wire [31:0] dat_o;
    wire ack_o, rx_irq, tx_irq;
    wire [3:0] ser_in, ser_out, dtr, carrier, ring;
    integer err_total = 0;
    integer checks_done = 0;
    integer i;
    reg [15:0] rv; // last read value
    // 200 mhz clock
    always #2.5 clk = ~clk;
    // ten clocks per bit at the fastest rate
    qlm_top #(.CLK_HZ(96000)) dut (.clk(clk), .resetn(resetn),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .ser_in(ser_in), .ser_out(ser_out), .dtr(dtr),
        .carrier(carrier), .ring(ring), .rx_irq(rx_irq), .tx_irq(tx_irq));
    qlm_term_model term (.ser_out(ser_out), .dtr(dtr),
        .ext_loop(ext_loop), .ser_in(ser_in), .carrier(carrier),
        .ring(ring));
    // ================================================================
    // verdict, compare and bus tasks
    task give_verdict;
        begin
            if (err_total == 0 && checks_done > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask
    task cmp(input [15:0] got, input [15:0] exp, input [15:0] mask);
        begin
            checks_done = checks_done + 1;
            if ((got & mask) !== (exp & mask)) begin
                err_total = err_total + 1;
                $display("Error at %0t: got %h expected %h mask %h",
                    $time, got, exp, mask);
            end
        end
    endtask
    // one classic cycle, held until ack is seen
    task bus(input w, input [7:0] a, input [15:0] d, output [15:0] q);
        integer n;
        begin
            @(posedge clk);
            cyc_i <= 1'b1;
            stb_i <= 1'b1;
            we_i <= w;
            adr_i <= a;
            dat_i <= {16'h0000, d};
            n = 0;
            @(posedge clk);
            while (ack_o !== 1'b1 && n < 20) begin
                @(posedge clk);
                n = n + 1;
            end
            q = dat_o[15:0];
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            we_i <= 1'b0;
            if (n == 20) begin
                err_total = err_total + 1;
                $display("Error at %0t: no bus answer", $time);
            end
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        bus(1'b1, a, d, rv);
    endtask
    task rdc(input [7:0] a, input [15:0] e, input [15:0] m);
        begin
            bus(1'b0, a, 16'h0000, rv);
            cmp(rv, e, m);
        end
    endtask
    // poll until a line is ready, check the line
    task wait_rdy(input [1:0] ln);
        integer n;
        begin
            n = 0;
            rv = 16'h0000;
            while (rv[15] !== 1'b1 && n < 400) begin
                bus(1'b0, `QLM_OFF_CSR, 16'h0000, rv);
                n = n + 1;
            end
            cmp(rv, {6'h20, ln, 8'h00}, 16'h8300);
        end
    endtask
    task send(input [1:0] ln, input [7:0] c);
        begin
            wait_rdy(ln);
            wr(`QLM_OFF_MSR, {8'h00, c});
        end
    endtask
    task do_reset;
        begin
            @(posedge clk);
            resetn <= 1'b0;
            repeat (12) @(posedge clk);
            resetn <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask
    // ================================================================
    // watchdog against a hang
    initial begin
        repeat (40000) @(posedge clk);
        err_total = err_total + 1;
        give_verdict;
    end
    // ================================================================
    // test sequence
    initial begin
        do_reset;
        rdc(`QLM_OFF_CSR, 16'h0000, 16'hFFFF);
        rdc(8'h10, 16'h0000, 16'hFFFF);
        wr(`QLM_OFF_CSR, 16'hF3EC);
        rdc(`QLM_OFF_CSR, 16'h506C, 16'hF0FC);
        wr(`QLM_OFF_CSR, 16'h507C);
        repeat (4) @(posedge clk);
        rdc(`QLM_OFF_CSR, 16'h0044, 16'hFFFF);
        wr(`QLM_OFF_CSR, 16'h0000);
        rdc(`QLM_OFF_CSR, 16'h0000, 16'hFFFF);
        // master clear in mid-run
        wr(`QLM_OFF_CSR, 16'h506C);
        wr(`QLM_OFF_TCR, 16'h0F0F);
        rdc(`QLM_OFF_TCR, 16'h0F0F, 16'hFFFF);
        cmp({12'h000, dtr}, 16'h000F, 16'hFFFF);
        wr(`QLM_OFF_MSR, 16'h00FF);
        rdc(`QLM_OFF_MSR, 16'h0F0F, 16'h0F0F);
        do_reset;
        rdc(`QLM_OFF_TCR, 16'h0000, 16'hFFFF);
        cmp({12'h000, dtr}, 16'h0000, 16'hFFFF);
        rdc(`QLM_OFF_CSR, 16'h0000, 16'hFFFF);
        // internal loop on line 0: alarm, overrun and order
        wr(`QLM_OFF_TCR, 16'h0001);
        wr(`QLM_OFF_RX_BUFFER_REG, 16'h1E00);
        rdc(`QLM_OFF_RX_BUFFER_REG, 16'h0000, 16'h8000);
        wr(`QLM_OFF_CSR, 16'h5068);
        for (i = 0; i < 65; i = i + 1) begin
            send(2'd0, i[7:0]);
            if (i == 14 || i == 15) begin
                wait_rdy(2'd0);
                rdc(`QLM_OFF_CSR, {2'b00, i[0], 13'h0000}, 16'h2000);
                cmp({12'h000, ser_out}, 16'h000F, 16'h000F);
                rv = {rx_irq, tx_irq, 14'h0000};
                cmp(rv, 16'h4000 << i[0], 16'hC000);
            end
        end
        wait_rdy(2'd0);
        rdc(`QLM_OFF_RX_BUFFER_REG, 16'hC000, 16'hC3FF);
        for (i = 1; i < 64; i = i + 1) begin
            rdc(`QLM_OFF_RX_BUFFER_REG, {8'h80, i[7:0]}, 16'hC3FF);
        end
        rdc(`QLM_OFF_RX_BUFFER_REG, 16'h0000, 16'h8000);
        // receiver of line 0 switched off
        wr(`QLM_OFF_RX_BUFFER_REG, 16'h0E00);
        send(2'd0, 8'h55);
        wait_rdy(2'd0);
        rdc(`QLM_OFF_CSR, 16'h0000, 16'h0080);
        // staggered pairing, then device clear
        wr(`QLM_OFF_RX_BUFFER_REG, 16'h1E01);
        wr(`QLM_OFF_CSR, 16'h002C);
        send(2'd0, 8'hA5);
        wait_rdy(2'd0);
        rdc(`QLM_OFF_RX_BUFFER_REG, 16'h81A5, 16'hC3FF);
        send(2'd0, 8'h3C);
        wait_rdy(2'd0);
        wr(`QLM_OFF_CSR, 16'h0010);
        repeat (4) @(posedge clk);
        rdc(`QLM_OFF_RX_BUFFER_REG, 16'h0000, 16'h8000);
        rdc(`QLM_OFF_CSR, 16'h0000, 16'hA390);
        // external plug on line 2 loops the line to itself
        ext_loop <= 1'b1;
        wr(`QLM_OFF_TCR, 16'h0004);
        wr(`QLM_OFF_RX_BUFFER_REG, 16'h1D02);
        wr(`QLM_OFF_CSR, 16'h0020);
        send(2'd2, 8'h96);
        wait_rdy(2'd2);
        rdc(`QLM_OFF_RX_BUFFER_REG, 16'h8296, 16'hC3FF);
        give_verdict;
    end
endmodule
